// ===== bsi_ctl_model.sv
// Board test controller model that drives the four-wire test link.
// Assumes its tasks are called one at a time by the bench; the test clock rests low.
`timescale 1ns/10ps
module bsi_ctl_model
(
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input wire logic  tdo,
    input wire logic  tdo_oe
);
    // Idle pins: clock low, mode select and data at their pull-up level.
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One 125 ns test clock period, far under the 50 MHz ceiling; tdo sampled late low.
    task automatic step(input logic m, input logic d, output logic o, output logic e);
        tms = m;
        tdi = d;
        #31 tck = 1'b1;
        #62 tck = 1'b0;
        #28 o = tdo;
        e = tdo_oe;
        #4;
    endtask
    // Idle to shift, w bits LSB first, then update and back to idle.
    task automatic scan(input logic ir, input int w, input logic [112:0] din,
                        output logic [112:0] dout, output logic oe_ok);
        logic o;
        logic e;
        #0.5;
        dout = '0;
        step(1'b1, 1'b1, o, e);
        if (ir)
            step(1'b1, 1'b1, o, e);
        step(1'b0, 1'b1, o, e);
        step(1'b0, 1'b1, o, e);
        dout[0] = o;
        oe_ok = e;
        for (int i = 0; i < w; i++)
        begin
            step(i == w - 1, din[i], o, e);
            dout[i+1] = (i < w - 1) ? o : 1'b0;
            oe_ok &= (i < w - 1) ? e : !e;
        end
        step(1'b1, 1'b1, o, e);
        step(1'b0, 1'b1, o, e);
    endtask
endmodule

// ===== bsi_pkg.sv
// Shared constants, types and decode helpers of the boundary-scan instruction unit.
// Assumes a single core clock that oversamples the test clock pin by at least four.
//
// Behaviour
// - Eight-bit instruction register, six implemented codes.
// - Standard test access port states and scan behaviour.
// - Shift-IR puts instruction register between TDI/TDO.
// - New instruction takes effect only at update-IR.
// - EXTEST drives output cells, captures input cells.
// - EXTEST at update-IR enables drivers with preloaded data.
// - IDCODE shifts fixed 32-bit identification out.
// - IDCODE active after power-up and test-logic-reset.
// - HIGH-Z forces all functional outputs high-impedance.
// - CLAMP drives outputs from held boundary cells.
// - SAMPLE capture-DR snapshots all pin levels.
// - Shift-DR then shifts boundary register out serially.
// - Pins toggling during capture give undefined bits.
// - BYPASS puts one-bit bypass register in chain.
// - EXTEST 00, IDCODE 21, SAMPLE 05 hex.
// - CLAMP 07, HIGH-Z 03, BYPASS FF hex.
// - Boundary-scan register is 113 cells long.
package bsi_pkg;

    // Register widths.
    localparam int IR_W    = 8;    // Instruction register width.
    localparam int ID_W    = 32;   // Identification register width.
    localparam int BSR_LEN = 113;  // Boundary-scan register length.

    // Instruction encodings.
    localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
    localparam logic [IR_W-1:0] OP_IDCODE = 8'h21;
    localparam logic [IR_W-1:0] OP_SAMPLE = 8'h05;
    localparam logic [IR_W-1:0] OP_CLAMP  = 8'h07;
    localparam logic [IR_W-1:0] OP_HIGHZ  = 8'h03;
    localparam logic [IR_W-1:0] OP_BYPASS = 8'hFF;

    // Pattern loaded into the instruction shifter at capture-IR.
    localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;

    // Test access port controller states.
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } bsi_tap_e;

    // Data register chosen by the active instruction.
    typedef enum logic [1:0] {
        DR_BYP, DR_BSR, DR_ID
    } bsi_dr_e;

    // Maps an instruction to its data register; unknown codes fall to bypass.
    function automatic bsi_dr_e dr_select(input logic [IR_W-1:0] ir);
        bsi_dr_e sel;
        sel = DR_BYP;
        case (ir)
            OP_EXTEST: sel = DR_BSR;
            OP_SAMPLE: sel = DR_BSR;
            OP_IDCODE: sel = DR_ID;
            default:   sel = DR_BYP;
        endcase
        return sel;
    endfunction

endpackage

// ===== bsi_tap.sv
// Top of the boundary-scan instruction unit: pin sampling, scan registers, output control.
// Assumes core_clk is far faster than the test clock and that pins are asynchronous.
`timescale 1ns/10ps
module bsi_tap
#(
    parameter int              BSR_W   = bsi_pkg::BSR_LEN,  // Boundary-scan cells.
    parameter logic [31:0]     ID_CODE = 32'h1000_0001      // Arbitrary value; bit 0 set.
)
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    output logic                  tdo,
    output logic                  tdo_oe,
    input  wire logic [BSR_W-1:0] pin_level,
    output logic [BSR_W-1:0]      test_data,
    output logic                  test_drive,
    output logic                  test_hiz,
    output logic [7:0]            active_instr
);

    // All state of the top module.
    typedef struct packed {
        logic                     tck_s1;    // Test clock, first sync stage.
        logic                     tck_s2;    // Test clock, second sync stage.
        logic                     tck_s3;    // Test clock history for edge finding.
        logic                     tms_s1;    // Mode select, first stage.
        logic                     tms_s2;    // Mode select, second stage.
        logic                     tdi_s1;    // Data in, first stage.
        logic                     tdi_s2;    // Data in, second stage.
        logic [BSR_W-1:0]         pin_s1;    // Pin levels, first stage.
        logic [BSR_W-1:0]         pin_s2;    // Pin levels, second stage.
        logic [bsi_pkg::IR_W-1:0] ir_sh;     // Instruction shifter.
        logic [bsi_pkg::IR_W-1:0] ir;        // Active instruction.
        logic [BSR_W-1:0]         bsr_sh;    // Boundary-scan shift stage.
        logic [BSR_W-1:0]         bsr_upd;   // Boundary-scan held outputs.
        logic [bsi_pkg::ID_W-1:0] id_sh;     // Identification register.
        logic                     byp;       // Bypass register.
        logic                     tdo;       // Serial out.
        logic                     tdo_oe;    // Serial out enable.
        logic                     drive;     // Outputs taken from held cells.
        logic                     hiz;       // Outputs forced off.
    } bsi_top_s;

    bsi_top_s st;       // Registered state.
    bsi_top_s next_st;  // Next state.

    bsi_tap_if tap ();  // Link to the controller.

    logic            rise;  // Test clock rising edge seen.
    logic            fall;  // Test clock falling edge seen.
    bsi_pkg::bsi_dr_e sel;   // Data register selected now.

    assign rise     = st.tck_s2 & ~st.tck_s3;
    assign fall     = ~st.tck_s2 & st.tck_s3;
    assign sel      = bsi_pkg::dr_select(st.ir);
    assign tap.step = rise;
    assign tap.tms  = st.tms_s2;

    // Controller that walks the standard state sequence.
    bsi_tap_fsm u_fsm
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tap      (tap)
    );

    // Outputs come straight from the state flops.
    assign tdo          = st.tdo;
    assign tdo_oe       = st.tdo_oe;
    assign test_data    = st.bsr_upd;
    assign test_drive   = st.drive;
    assign test_hiz     = st.hiz;
    assign active_instr = st.ir;

    // Synchronises pins and performs the scan action of the current state.
    always_comb
    begin
        next_st        = st;
        next_st.tck_s1 = tck;
        next_st.tck_s2 = st.tck_s1;
        next_st.tck_s3 = st.tck_s2;
        next_st.tms_s1 = tms;
        next_st.tms_s2 = st.tms_s1;
        next_st.tdi_s1 = tdi;
        next_st.tdi_s2 = st.tdi_s1;
        next_st.pin_s1 = pin_level;
        next_st.pin_s2 = st.pin_s1;
        // Actions on the test clock rising edge, keyed on the state being left.
        if (rise)
        begin
            case (tap.state)
                bsi_pkg::TLR:
                    next_st.ir = bsi_pkg::OP_IDCODE;
                bsi_pkg::CAP_IR:
                    next_st.ir_sh = bsi_pkg::IR_CAPTURE;
                bsi_pkg::SHIFT_IR:
                    next_st.ir_sh = {st.tdi_s2, st.ir_sh[bsi_pkg::IR_W-1:1]};
                bsi_pkg::UPD_IR:
                    next_st.ir = st.ir_sh;
                bsi_pkg::CAP_DR:
                begin
                    // Any bit whose pin moved near this edge may land either way.
                    case (sel)
                        bsi_pkg::DR_BSR: next_st.bsr_sh = st.pin_s2;
                        bsi_pkg::DR_ID:  next_st.id_sh  = ID_CODE;
                        default:         next_st.byp    = 1'b0;
                    endcase
                end
                bsi_pkg::SHIFT_DR:
                begin
                    case (sel)
                        bsi_pkg::DR_BSR: next_st.bsr_sh = {st.tdi_s2, st.bsr_sh[BSR_W-1:1]};
                        bsi_pkg::DR_ID:  next_st.id_sh  = {st.tdi_s2, st.id_sh[bsi_pkg::ID_W-1:1]};
                        default:         next_st.byp    = st.tdi_s2;
                    endcase
                end
                bsi_pkg::UPD_DR:
                begin
                    // Held cells change only here; this is how a preload reaches the pins.
                    if (sel == bsi_pkg::DR_BSR)
                        next_st.bsr_upd = st.bsr_sh;
                end
                default:
                    next_st.ir = st.ir;
            endcase
        end
        // Serial out changes on the falling edge and is driven only while shifting.
        if (fall)
        begin
            next_st.tdo    = 1'b0;
            next_st.tdo_oe = 1'b0;
            if (tap.state == bsi_pkg::SHIFT_IR)
            begin
                next_st.tdo    = st.ir_sh[0];
                next_st.tdo_oe = 1'b1;
            end
            else if (tap.state == bsi_pkg::SHIFT_DR)
            begin
                next_st.tdo_oe = 1'b1;
                case (sel)
                    bsi_pkg::DR_BSR: next_st.tdo = st.bsr_sh[0];
                    bsi_pkg::DR_ID:  next_st.tdo = st.id_sh[0];
                    default:         next_st.tdo = st.byp;
                endcase
            end
        end
        // Pin control follows the active instruction.
        next_st.drive = (next_st.ir == bsi_pkg::OP_EXTEST)
                      | (next_st.ir == bsi_pkg::OP_CLAMP);
        next_st.hiz   = (next_st.ir == bsi_pkg::OP_HIGHZ);
    end

    // Registers the whole state; reset restores the identification instruction.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st    <= '0;
            st.ir <= bsi_pkg::OP_IDCODE;
        end
        else
            st <= next_st;
    end

endmodule

// ===== bsi_tap_fsm.sv
// Sixteen-state test access port controller, advanced once per test clock rise.
// Assumes step and tms arrive already synchronised to core_clk.
`timescale 1ns/10ps
module bsi_tap_fsm
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    bsi_tap_if.fsm    tap
);

    // All state of this module.
    typedef struct packed {
        bsi_pkg::bsi_tap_e state;  // Controller state.
    } bsi_fsm_s;

    bsi_fsm_s st;       // Registered state.
    bsi_fsm_s next_st;  // Next state.

    assign tap.state = st.state;

    // Computes the next controller state from the mode select level.
    always_comb
    begin
        next_st = st;
        if (tap.step)
        begin
            case (st.state)
                bsi_pkg::TLR:      next_st.state = tap.tms ? bsi_pkg::TLR      : bsi_pkg::RTI;
                bsi_pkg::RTI:      next_st.state = tap.tms ? bsi_pkg::SEL_DR   : bsi_pkg::RTI;
                bsi_pkg::SEL_DR:   next_st.state = tap.tms ? bsi_pkg::SEL_IR   : bsi_pkg::CAP_DR;
                bsi_pkg::CAP_DR:   next_st.state = tap.tms ? bsi_pkg::EXIT1_DR : bsi_pkg::SHIFT_DR;
                bsi_pkg::SHIFT_DR: next_st.state = tap.tms ? bsi_pkg::EXIT1_DR : bsi_pkg::SHIFT_DR;
                bsi_pkg::EXIT1_DR: next_st.state = tap.tms ? bsi_pkg::UPD_DR   : bsi_pkg::PAUSE_DR;
                bsi_pkg::PAUSE_DR: next_st.state = tap.tms ? bsi_pkg::EXIT2_DR : bsi_pkg::PAUSE_DR;
                bsi_pkg::EXIT2_DR: next_st.state = tap.tms ? bsi_pkg::UPD_DR   : bsi_pkg::SHIFT_DR;
                bsi_pkg::UPD_DR:   next_st.state = tap.tms ? bsi_pkg::SEL_DR   : bsi_pkg::RTI;
                bsi_pkg::SEL_IR:   next_st.state = tap.tms ? bsi_pkg::TLR      : bsi_pkg::CAP_IR;
                bsi_pkg::CAP_IR:   next_st.state = tap.tms ? bsi_pkg::EXIT1_IR : bsi_pkg::SHIFT_IR;
                bsi_pkg::SHIFT_IR: next_st.state = tap.tms ? bsi_pkg::EXIT1_IR : bsi_pkg::SHIFT_IR;
                bsi_pkg::EXIT1_IR: next_st.state = tap.tms ? bsi_pkg::UPD_IR   : bsi_pkg::PAUSE_IR;
                bsi_pkg::PAUSE_IR: next_st.state = tap.tms ? bsi_pkg::EXIT2_IR : bsi_pkg::PAUSE_IR;
                bsi_pkg::EXIT2_IR: next_st.state = tap.tms ? bsi_pkg::UPD_IR   : bsi_pkg::SHIFT_IR;
                bsi_pkg::UPD_IR:   next_st.state = tap.tms ? bsi_pkg::SEL_DR   : bsi_pkg::RTI;
                default:           next_st.state = bsi_pkg::TLR;
            endcase
        end
    end

    // Registers the state; reset lands in test-logic-reset.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '{state: bsi_pkg::TLR};
        else
            st <= next_st;
    end

endmodule

// ===== bsi_tap_if.sv
// Interface carrying the test clock step and the controller state between modules.
// Assumes the step pulse lasts one core clock per test clock rising edge.
`timescale 1ns/10ps
interface bsi_tap_if;
    logic             step;   // One-cycle pulse at each test clock rising edge.
    logic             tms;    // Synchronised mode select level.
    bsi_pkg::bsi_tap_e state;  // Current controller state.

    // Side that owns the state machine.
    modport fsm
    (
        input  step,
        input  tms,
        output state
    );

    // Side that acts on the state.
    modport user
    (
        output step,
        output tms,
        input  state
    );
endinterface

// ===== bsi_tap_properties.sv
// Checker of the boundary-scan instruction unit, watching only its top ports.
// Assumes the test clock pin is far slower than core_clk and is held high and low long.
`timescale 1ns/10ps
module bsi_tap_properties
#(
    parameter int BSR_W = 113
)
(
    input wire logic             core_clk,
    input wire logic             rst_n,
    input wire logic             tck,
    input wire logic             tms,
    input wire logic             tdo,
    input wire logic             tdo_oe,
    input wire logic [BSR_W-1:0] test_data,
    input wire logic             test_drive,
    input wire logic             test_hiz,
    input wire logic [7:0]       active_instr
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic       tck_d;  // Test clock level one cycle back.
    logic [2:0] ones;   // Rises in a row taken with mode select high, saturating.
    // Counts test clock rises with mode select high; a low one clears the count.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tck_d <= 1'b0;
            ones  <= 3'h0;
        end
        else
        begin
            tck_d <= tck;
            if (tck && !tck_d)
                ones <= !tms ? 3'h0 : (ones == 3'h7 ? ones : ones + 3'h1);
        end
    end
    AST_TDO_FALL: assert property ($changed(tdo) |-> !tck && !$past(tck, 2))
        else $error("tdo moved outside a low test clock phase.");
    AST_OE_FALL: assert property ($changed(tdo_oe) |-> !tck && !$past(tck, 2))
        else $error("tdo_oe moved outside a low test clock phase.");
    AST_INSTR_RISE: assert property ($changed(active_instr) |-> tck && $past(tck, 2))
        else $error("Active instruction moved outside a high test clock phase.");
    AST_DRIVE_DECODE: assert property (test_drive == (active_instr inside {8'h00, 8'h07}))
        else $error("test_drive does not match the active instruction.");
    AST_HIZ_DECODE: assert property (test_hiz == (active_instr == 8'h03))
        else $error("test_hiz does not match the active instruction.");
    AST_DATA_UPDATE: assert property ($changed(test_data) |-> tck && active_instr inside {8'h00, 8'h05})
        else $error("Held boundary cells changed without an update.");
    AST_TLR_DEFAULT: assert property (ones == 3'h7 |-> active_instr == 8'h21)
        else $error("Identification not active after a test logic reset.");
    AST_RESET_VALUES: assert property ($rose(rst_n) |-> active_instr == 8'h21 && !tdo_oe && !test_drive)
        else $error("Wrong output values right after reset.");
    // Main scenarios: pins driven, pins floated, a scan running.
    cover property ($rose(test_drive));
    cover property ($rose(test_hiz));
    cover property ($rose(tdo_oe));
endmodule

bind bsi_tap bsi_tap_properties #(.BSR_W(BSR_W)) i_props (.core_clk(core_clk), .rst_n(rst_n),
    .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe), .test_data(test_data),
    .test_drive(test_drive), .test_hiz(test_hiz), .active_instr(active_instr));

// ===== test_boundary_scan_instruction_unit.sv
// Self-checking bench of the boundary-scan instruction unit with a controller model.
// Assumes the design, its package and interface are compiled beforehand.
`timescale 1ns/10ps
module test_boundary_scan_instruction_unit;
    localparam logic [31:0] ID = 32'h1234_5679;  // Arbitrary value with bit 0 set.
    logic         core_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, test_drive, test_hiz, o, e;
    logic         oe_ok;
    logic [112:0] pin_level, test_data, din, dout, exp_td;
    logic [7:0]   active_instr;
    logic [31:0]  seed = 32'h388D;
    int           errors = 0;
    int           comparisons = 0;
    // Preload before drive, then the rest; reserved codes are never loaded.
    logic [7:0]   codes [7] = '{8'h05, 8'h00, 8'h07, 8'h03, 8'hFF, 8'h05, 8'h21};
    bsi_tap #(.BSR_W(113), .ID_CODE(ID)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_level(pin_level),
        .test_data(test_data), .test_drive(test_drive), .test_hiz(test_hiz),
        .active_instr(active_instr));
    bsi_ctl_model i_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    // Next xorshift value.
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Expected 113 bits out of a data scan for the active code.
    function automatic logic [112:0] exp_scan(input logic [7:0] c, input logic [112:0] d,
                                              input logic [112:0] p);
        if (c == 8'h00 || c == 8'h05)
            return p;
        if (c == 8'h21)
            return {d[80:0], ID};
        return {d[111:0], 1'b0};
    endfunction
    // Draws new scan data and new pin levels, held through the scan.
    // Pins stay still through the scan, so every captured bit is checked.
    task automatic roll;
        for (int i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            din = {din[80:0], seed};
            seed = xs(seed);
            pin_level = {pin_level[80:0], seed};
        end
    endtask
    // Compares and counts.
    task automatic check(input logic [112:0] seen, input logic [112:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Core clock of 4 ns.
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Cuts a hang short.
    initial
    begin
        #390000;
        errors++;
        tally_and_finish;
    end
    // Main sequence.
    initial
    begin
        rst_n = 1'b0;
        pin_level = '0;
        din = '0;
        exp_td = '0;
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        check(active_instr, 8'h21);
        check({tdo_oe, test_drive, test_hiz}, 3'h0);
        i_ctl.step(1'b0, 1'b1, o, e);
        foreach (codes[k])
        begin
            i_ctl.scan(1'b1, 8, codes[k], dout, oe_ok);
            check(dout[7:0], 8'h01);
            check(active_instr, codes[k]);
            check({test_drive, test_hiz}, {codes[k] inside {8'h00, 8'h07}, codes[k] == 8'h03});
            @(negedge core_clk);
            roll();
            i_ctl.scan(1'b0, 113, din, dout, oe_ok);
            check(dout, exp_scan(codes[k], din, pin_level));
            check(oe_ok, 1'b1);
            exp_td = (codes[k] inside {8'h00, 8'h05}) ? din : exp_td;
            check(test_data, exp_td);
            $display("Code %h done.", codes[k]);
        end
        for (int i = 0; i < 7; i++)
            i_ctl.step(1'b1, 1'b1, o, e);
        check(active_instr, 8'h21);
        i_ctl.step(1'b0, 1'b1, o, e);
        i_ctl.scan(1'b0, 113, din, dout, oe_ok);
        check(dout[31:0], ID);
        $display("Test logic reset done.");
        i_ctl.scan(1'b1, 8, 8'hFF, dout, oe_ok);
        @(negedge core_clk);
        rst_n = 1'b0;
        @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        check({active_instr, tdo_oe}, {8'h21, 1'b0});
        $display("Mid-run reset done.");
        tally_and_finish;
    end
endmodule
